// >>> core/eecs_pkg.sv
// eecs_pkg: constants and carrier types of the eeprom command sequencer
// assumes a single bus clock; all host strobes arrive on that clock
package eecs_pkg;
  localparam int EECS_AW        = 12; // byte address width of the array
  localparam int EECS_DW        = 16; // word width
  localparam int EECS_CW        = 7;  // command code width
  localparam int EECS_DIVW      = 7;  // prescale bit plus six divider bits
  localparam int EECS_PRDIV_BIT = 6;

  localparam logic [6:0] EECS_CMD_VERIFY = 7'h05;
  localparam logic [6:0] EECS_CMD_PROG   = 7'h20;
  localparam logic [6:0] EECS_CMD_SECT   = 7'h40;
  localparam logic [6:0] EECS_CMD_MASS   = 7'h41;
  localparam logic [6:0] EECS_CMD_ABORT  = 7'h47;
  localparam logic [6:0] EECS_CMD_MODIFY = 7'h60;

  localparam logic [2:0]  EECS_LAUNCH_CYCLES = 3'h4;
  localparam int          EECS_EV_OVERHEAD   = 14;
  // launch pipe plus engine start and flag update
  localparam int          EECS_EV_LAT        = int'(EECS_LAUNCH_CYCLES) + 3;
  localparam int          EECS_ABORT_TICKS   = 4;
  localparam int          EECS_ABORT_BUS     = 5;
  localparam int          EECS_PRESCALE      = 8;
  localparam logic [15:0] EECS_ERASED        = 16'hffff;

  typedef struct packed {
    logic [EECS_CW-1:0] code;
    logic [EECS_AW-1:0] addr;
    logic [EECS_DW-1:0] data;
  } eecs_cmd_t;

  typedef struct packed {
    logic buffer_empty_flag;
    logic completion_flag;
    logic protection_violation_flag;
    logic access_error_flag;
    logic erased_flag;
  } eecs_stat_t;

  localparam eecs_stat_t EECS_STAT_RST = 5'h18;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_ADDR = 2'b01,
    SQ_CMD  = 2'b11
  } eecs_seq_t;

  typedef enum logic [2:0] {
    EN_IDLE   = 3'b000,
    EN_VERIFY = 3'b001,
    EN_ERASE  = 3'b011,
    EN_PROG   = 3'b010,
    EN_ABORT  = 3'b110
  } eecs_eng_t;
endpackage

// >>> core/eecs_tick.sv
// eecs_tick: timing clock strobe for the embedded algorithms
// assumes the divider value is stable while run_i is high
`timescale 1ns/1ps
module eecs_tick (
  input  wire logic                          clock_i,  // bus clock
  input  wire logic                          resetn_i, // async reset, active low
  input  wire logic [eecs_pkg::EECS_DIVW-1:0] div_i,   // prescale bit, divider
  input  wire logic                          run_i,    // algorithm active
  output logic                               tick_o    // one timing clock period
);
  logic [8:0] cnt_r;
  logic [8:0] limit;

  // period is (div+1) bus cycles, times eight with the prescaler
  always_comb begin
    if (div_i[eecs_pkg::EECS_PRDIV_BIT]) begin
      limit = {div_i[5:0], 3'h7};
    end else begin
      limit = {3'h0, div_i[5:0]};
    end
  end

  assign tick_o = run_i && (cnt_r == limit);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 9'h000;
    end else if (!run_i || cnt_r == limit) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_r + 9'h001;
    end
  end
endmodule

// >>> core/eecs_sequencer.sv
// eecs_sequencer: command write sequence, launch buffer and algorithm engine
// assumes host strobes are single-cycle and synchronous to clock_i
`timescale 1ns/1ps

module eecs_sequencer #(
  parameter int WORDS       = 2048, // array size in words
  parameter int PROG_TICKS  = 8,    // program pulse in timing clock periods
  parameter int ERASE_TICKS = 16,   // sector erase pulse
  parameter int MASS_TICKS  = 32    // mass erase pulse
) (
  input  wire logic                          clock_i,         // bus clock 125 MHz
  input  wire logic                          resetn_i,        // async reset, active low
  input  wire logic                          array_wr_i,      // array write strobe
  input  wire logic [eecs_pkg::EECS_AW-1:0]  array_addr_i,    // array byte address
  input  wire logic [eecs_pkg::EECS_DW-1:0]  array_data_i,    // array write data
  input  wire logic                          cmd_wr_i,        // command register write
  input  wire logic [eecs_pkg::EECS_CW-1:0]  cmd_code_i,      // command code field
  input  wire logic                          stat_wr_i,       // status register write
  input  wire eecs_pkg::eecs_stat_t          stat_wdata_i,    // status write, 1 acts
  input  wire logic                          clkdiv_wr_i,     // divider register write
  input  wire logic [eecs_pkg::EECS_DIVW-1:0] clkdiv_data_i,  // divider value
  input  wire logic                          prot_open_i,     // protection open bit
  input  wire logic                          prot_disable_i,  // protection disable bit
  input  wire logic [eecs_pkg::EECS_AW-1:0]  prot_base_i,     // first protected address
  input  wire logic [eecs_pkg::EECS_AW-1:0]  rd_addr_i,       // array read address
  output logic      [eecs_pkg::EECS_DW-1:0]  rd_data_o,       // array read data
  output eecs_pkg::eecs_stat_t               status_o,        // status register flags
  output logic                               divider_loaded_o // divider written
);
  localparam int IW = eecs_pkg::EECS_AW - 1;
  localparam logic [11:0] EV_LAST =
    12'(WORDS + eecs_pkg::EECS_EV_OVERHEAD - eecs_pkg::EECS_EV_LAT);

  logic [eecs_pkg::EECS_DW-1:0] mem [WORDS];

  eecs_pkg::eecs_seq_t  seq_r, seq_nxt;
  eecs_pkg::eecs_eng_t  eng_r;
  eecs_pkg::eecs_cmd_t  buf_r, pend_r, act_r;
  eecs_pkg::eecs_stat_t stat_r;
  logic                 pend_v_r, abort_act_r, abort_cut_r, blank_r;
  logic [2:0]           lc_r;
  logic [11:0]          cnt_r;
  logic [7:0]           tk_r;
  logic [eecs_pkg::EECS_DIVW-1:0] div_r;
  logic                 div_ld_r;
  logic                 launch, set_acc, set_pv, ld_addr, ld_code;
  logic                 tick, is_mass, cut_ev, erase_fin, prog_fin, take, done_ok;
  logic                 abort_done, cc_set;
  logic [IW-1:0]        widx;

  function automatic logic cmd_valid(input logic [6:0] c);
    return c == eecs_pkg::EECS_CMD_VERIFY || c == eecs_pkg::EECS_CMD_PROG ||
           c == eecs_pkg::EECS_CMD_SECT   || c == eecs_pkg::EECS_CMD_MASS ||
           c == eecs_pkg::EECS_CMD_ABORT  || c == eecs_pkg::EECS_CMD_MODIFY;
  endfunction

  // whole array is locked while the open bit is low
  function automatic logic prot_hit(input logic [eecs_pkg::EECS_AW-1:0] a);
    return !prot_open_i || (!prot_disable_i && a >= prot_base_i);
  endfunction

  assign status_o         = stat_r;
  assign divider_loaded_o = div_ld_r;
  assign is_mass          = act_r.code == eecs_pkg::EECS_CMD_MASS;
  assign widx             = act_r.addr[eecs_pkg::EECS_AW-1:1];
  assign take             = eng_r == eecs_pkg::EN_IDLE && pend_v_r && !abort_act_r;
  assign cut_ev           = eng_r == eecs_pkg::EN_ERASE && abort_act_r && !is_mass;
  assign erase_fin        = eng_r == eecs_pkg::EN_ERASE && !cut_ev &&
                            tk_r >= 8'(is_mass ? MASS_TICKS : ERASE_TICKS) &&
                            (!is_mass || cnt_r >= 12'(WORDS));
  assign prog_fin         = eng_r == eecs_pkg::EN_PROG && tk_r >= 8'(PROG_TICKS);
  assign abort_done       = abort_act_r && eng_r == eecs_pkg::EN_IDLE;
  assign cc_set = eng_r == eecs_pkg::EN_IDLE && !pend_v_r && lc_r == 3'h0 &&
                  !abort_act_r && !stat_r.completion_flag;

  eecs_tick u_tick (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .div_i    (div_r),
    .run_i    (eng_r != eecs_pkg::EN_IDLE),
    .tick_o   (tick)
  );

  // command write sequence checker
  always_comb begin
    seq_nxt = seq_r;
    launch  = 1'b0;
    set_acc = 1'b0;
    set_pv  = 1'b0;
    ld_addr = 1'b0;
    ld_code = 1'b0;
    if (array_wr_i) begin
      if (!div_ld_r || abort_act_r || seq_r == eecs_pkg::SQ_CMD) begin
        set_acc = 1'b1;
        seq_nxt = eecs_pkg::SQ_IDLE;
      end else if (stat_r.buffer_empty_flag && !stat_r.access_error_flag &&
                   !stat_r.protection_violation_flag) begin
        ld_addr = 1'b1;
        seq_nxt = eecs_pkg::SQ_ADDR;
      end
    end else if (cmd_wr_i && seq_r != eecs_pkg::SQ_IDLE) begin
      seq_nxt = eecs_pkg::SQ_IDLE;
      if (seq_r == eecs_pkg::SQ_CMD || !cmd_valid(cmd_code_i)) begin
        set_acc = 1'b1;
      end else if (((cmd_code_i == eecs_pkg::EECS_CMD_PROG ||
                     cmd_code_i == eecs_pkg::EECS_CMD_SECT ||
                     cmd_code_i == eecs_pkg::EECS_CMD_MODIFY) && prot_hit(buf_r.addr)) ||
                   (cmd_code_i == eecs_pkg::EECS_CMD_MASS &&
                    !(prot_open_i && prot_disable_i))) begin
        set_pv = 1'b1;
      end else begin
        ld_code = 1'b1;
        seq_nxt = eecs_pkg::SQ_CMD;
      end
    end else if (stat_wr_i && seq_r != eecs_pkg::SQ_IDLE) begin
      seq_nxt = eecs_pkg::SQ_IDLE;
      // launch by writing one to buffer empty
      if (stat_wdata_i.buffer_empty_flag && seq_r == eecs_pkg::SQ_CMD) begin
        launch = 1'b1;
      end else begin
        set_acc = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq_r <= eecs_pkg::SQ_IDLE;
      buf_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      if (ld_addr) begin
        buf_r.addr <= array_addr_i;
        buf_r.data <= array_data_i;
      end
      if (ld_code) begin
        buf_r.code <= cmd_code_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r    <= '0;
      div_ld_r <= 1'b0;
    end else if (clkdiv_wr_i) begin
      div_r    <= clkdiv_data_i;
      div_ld_r <= 1'b1;
    end
  end

  // launch pipe into the second buffer stage; abort bypasses it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lc_r        <= 3'h0;
      pend_r      <= '0;
      pend_v_r    <= 1'b0;
      abort_act_r <= 1'b0;
    end else begin
      if (launch && buf_r.code != eecs_pkg::EECS_CMD_ABORT) begin
        lc_r <= eecs_pkg::EECS_LAUNCH_CYCLES;
      end else if (lc_r > 3'h1 || (lc_r == 3'h1 && !pend_v_r)) begin
        lc_r <= lc_r - 3'h1;
      end
      if (lc_r == 3'h1 && !pend_v_r) begin
        pend_r   <= buf_r;
        pend_v_r <= 1'b1;
      end else if (take) begin
        pend_v_r <= 1'b0;
      end
      if (launch && buf_r.code == eecs_pkg::EECS_CMD_ABORT) begin
        abort_act_r <= 1'b1;
      end else if (abort_done) begin
        abort_act_r <= 1'b0;
      end
    end
  end

  // algorithm engine
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      eng_r   <= eecs_pkg::EN_IDLE;
      act_r   <= '0;
      cnt_r   <= 12'h000;
      tk_r    <= 8'h00;
      blank_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 12'h001;
      if (tick && tk_r != 8'hff) begin
        tk_r <= tk_r + 8'h01;
      end
      unique case (eng_r)
        eecs_pkg::EN_IDLE: begin
          if (take) begin
            act_r   <= pend_r;
            cnt_r   <= 12'h000;
            tk_r    <= 8'h00;
            blank_r <= 1'b0;
            if (pend_r.code == eecs_pkg::EECS_CMD_VERIFY) begin
              eng_r   <= eecs_pkg::EN_VERIFY;
              blank_r <= 1'b1;
            end else if (pend_r.code == eecs_pkg::EECS_CMD_PROG) begin
              eng_r <= eecs_pkg::EN_PROG;
            end else begin
              eng_r <= eecs_pkg::EN_ERASE;
            end
          end
        end
        eecs_pkg::EN_VERIFY: begin
          if (cnt_r < 12'(WORDS) && mem[cnt_r[IW-1:0]] != eecs_pkg::EECS_ERASED) begin
            blank_r <= 1'b0;
            eng_r   <= eecs_pkg::EN_IDLE;
          end else if (cnt_r == EV_LAST) begin
            eng_r <= eecs_pkg::EN_IDLE;
          end
        end
        eecs_pkg::EN_ERASE: begin
          // abort of a sector erase or modify switches to the fixed shutdown
          if (cut_ev) begin
            eng_r <= eecs_pkg::EN_ABORT;
            tk_r  <= 8'h00;
          end else if (erase_fin) begin
            tk_r  <= 8'h00;
            eng_r <= (act_r.code == eecs_pkg::EECS_CMD_MODIFY) ? eecs_pkg::EN_PROG
                                                               : eecs_pkg::EN_IDLE;
          end
        end
        eecs_pkg::EN_PROG: begin
          if (prog_fin) begin
            eng_r <= eecs_pkg::EN_IDLE;
          end
        end
        eecs_pkg::EN_ABORT: begin
          if (tk_r >= 8'(eecs_pkg::EECS_ABORT_TICKS)) begin
            eng_r <= eecs_pkg::EN_IDLE;
          end
        end
        default: eng_r <= eecs_pkg::EN_IDLE;
      endcase
    end
  end

  // array cells: erase sets all ones, program only clears bits
  always_ff @(posedge clock_i) begin
    // mass sweep, one word a cycle
    if (eng_r == eecs_pkg::EN_ERASE && is_mass && cnt_r < 12'(WORDS)) begin
      mem[cnt_r[IW-1:0]] <= eecs_pkg::EECS_ERASED;
    end
    if (erase_fin && !is_mass) begin
      mem[{widx[IW-1:1], 1'b0}] <= eecs_pkg::EECS_ERASED;
      mem[{widx[IW-1:1], 1'b1}] <= eecs_pkg::EECS_ERASED;
    end
    if (prog_fin) begin
      mem[widx] <= mem[widx] & act_r.data;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i[eecs_pkg::EECS_AW-1:1]];
    end
  end

  // status flags; error set wins over software clear, launch clear wins over completion set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r      <= eecs_pkg::EECS_STAT_RST;
      abort_cut_r <= 1'b0;
    end else begin
      if (launch) begin
        stat_r.buffer_empty_flag <= 1'b0;
        stat_r.completion_flag   <= 1'b0;
        if (buf_r.code == eecs_pkg::EECS_CMD_VERIFY) begin
          stat_r.erased_flag <= 1'b0;
        end
      // buffer free four cycles after launch once the second stage is empty, or when an abort ends
      end else if ((lc_r == 3'h1 && !pend_v_r) || abort_done) begin
        stat_r.buffer_empty_flag <= 1'b1;
      end
      if (cut_ev) begin
        abort_cut_r <= 1'b1;
      end else if (cc_set && !launch) begin
        abort_cut_r <= 1'b0;
      end
      if (cc_set && !launch) begin
        stat_r.completion_flag <= 1'b1;
        if (blank_r) begin
          stat_r.erased_flag <= 1'b1;
        end
      end
      if (set_acc || (cc_set && !launch && abort_cut_r)) begin
        stat_r.access_error_flag <= 1'b1;
      end else if (stat_wr_i && stat_wdata_i.access_error_flag) begin
        stat_r.access_error_flag <= 1'b0;
      end
      if (set_pv) begin
        stat_r.protection_violation_flag <= 1'b1;
      end else if (stat_wr_i && stat_wdata_i.protection_violation_flag) begin
        stat_r.protection_violation_flag <= 1'b0;
      end
    end
  end

  // assertion helpers: cycle counts from launch
  logic        ev_trk_r, ab_trk_r;
  logic [11:0] ev_cnt_r, ab_cnt_r, ab_max;
  assign ab_max = 12'((int'(div_r[5:0]) + 1) *
                      (div_r[eecs_pkg::EECS_PRDIV_BIT] ? eecs_pkg::EECS_PRESCALE : 1) *
                      eecs_pkg::EECS_ABORT_TICKS + eecs_pkg::EECS_ABORT_BUS);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ev_trk_r <= 1'b0;
      ab_trk_r <= 1'b0;
      ev_cnt_r <= 12'h000;
      ab_cnt_r <= 12'h000;
    end else begin
      ev_cnt_r <= launch ? 12'h000 : ev_cnt_r + 12'h001;
      ab_cnt_r <= launch ? 12'h000 : ab_cnt_r + 12'h001;
      ev_trk_r <= launch ? (buf_r.code == eecs_pkg::EECS_CMD_VERIFY && !pend_v_r &&
                            eng_r == eecs_pkg::EN_IDLE && lc_r == 3'h0)
                         : ev_trk_r && !stat_r.completion_flag;
      // bound only covers a cut sector erase or modify
      ab_trk_r <= launch ? (buf_r.code == eecs_pkg::EECS_CMD_ABORT && !pend_v_r &&
                            eng_r == eecs_pkg::EN_ERASE && !is_mass)
                         : ab_trk_r && !stat_r.completion_flag;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_plain_launch;
    launch && buf_r.code != eecs_pkg::EECS_CMD_ABORT && !pend_v_r && lc_r == 3'h0;
  endsequence
  sequence s_free_after_four;
    (!stat_r.buffer_empty_flag && !stat_r.completion_flag)[*4] ##1 stat_r.buffer_empty_flag;
  endsequence
  sequence s_verify_miss;
    eng_r == eecs_pkg::EN_VERIFY && cnt_r < 12'(WORDS) &&
    mem[cnt_r[IW-1:0]] != eecs_pkg::EECS_ERASED;
  endsequence

  a_buffer_free_four:
    assert property (s_plain_launch |=> s_free_after_four)
    else $error("buffer empty flag not set four cycles after launch");
  a_verify_cycle_count:
    assert property ($rose(stat_r.completion_flag) && ev_trk_r && stat_r.erased_flag
                     |-> ev_cnt_r == 12'(WORDS + eecs_pkg::EECS_EV_OVERHEAD))
    else $error("erase verify length wrong");
  a_erased_with_done:
    assert property ($rose(stat_r.erased_flag) |-> $rose(stat_r.completion_flag))
    else $error("erased flag set apart from completion");
  a_nonblank_stays_clear:
    assert property (s_verify_miss |=> !blank_r ##1 !stat_r.erased_flag)
    else $error("erased flag set after failed verify");
  a_prot_no_launch:
    assert property (set_pv |=> stat_r.protection_violation_flag && seq_r == eecs_pkg::SQ_IDLE
                     ##1 lc_r == 3'h0 && $stable(stat_r.completion_flag))
    else $error("protected command launched");
  a_abort_within_bound:
    assert property ($rose(stat_r.completion_flag) && ab_trk_r |-> ab_cnt_r <= ab_max)
    else $error("abort took too long");
  a_abort_cut_error:
    assert property (cut_ev ##1 !cut_ev[*1] ##[1:600] $rose(stat_r.completion_flag)
                     |-> stat_r.access_error_flag)
    else $error("cut erase without access error");
  a_abort_holds_buffer:
    assert property (abort_act_r && !abort_done |=> !stat_r.buffer_empty_flag)
    else $error("buffer empty during abort");
  a_no_divider_error:
    assert property (array_wr_i && !div_ld_r |=> stat_r.access_error_flag && seq_r == eecs_pkg::SQ_IDLE)
    else $error("array write accepted without divider");
  a_done_waits_buffer:
    assert property ($rose(stat_r.completion_flag) |-> !$past(pend_v_r) &&
                     eng_r == eecs_pkg::EN_IDLE)
    else $error("completion with command buffered");
endmodule

// >>> verification/eecs_sequencer_bench.sv
// eecs_sequencer_bench: self-checking bench for the command sequencer
// assumes one bus clock; the bench drives every input on falling edges
`timescale 1ns/1ps
module eecs_sequencer_bench;
  logic                 clock_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 array_wr_i = 1'b0;
  logic [11:0]          array_addr_i = 12'h000;
  logic [15:0]          array_data_i = 16'h0000;
  logic                 cmd_wr_i = 1'b0;
  logic [6:0]           cmd_code_i = 7'h00;
  logic                 stat_wr_i = 1'b0;
  eecs_pkg::eecs_stat_t stat_wdata_i = 5'h00;
  logic                 clkdiv_wr_i = 1'b0;
  logic [6:0]           clkdiv_data_i = 7'h00;
  logic                 prot_open_i = 1'b0;
  logic                 prot_disable_i = 1'b0;
  logic [11:0]          prot_base_i = 12'h800;
  logic [11:0]          rd_addr_i = 12'h000;
  logic [15:0]          rd_data_o;
  eecs_pkg::eecs_stat_t status_o;
  logic                 divider_loaded_o;
  int                   err_count = 0;
  int                   n_compared = 0;
  int                   n;
  logic [6:0]           bad [3] = '{7'h41, 7'h20, 7'h40};

  eecs_sequencer dut (.clock_i, .resetn_i, .array_wr_i, .array_addr_i, .array_data_i,
    .cmd_wr_i, .cmd_code_i, .stat_wr_i, .stat_wdata_i, .clkdiv_wr_i, .clkdiv_data_i,
    .prot_open_i, .prot_disable_i, .prot_base_i, .rd_addr_i, .rd_data_o, .status_o,
    .divider_loaded_o);

  always #4 clock_i = ~clock_i;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic stat_wr(input logic [4:0] w);
    stat_wr_i = 1'b1;
    stat_wdata_i = w;
    @(negedge clock_i);
    stat_wr_i = 1'b0;
  endtask

  // full sequence: array word, command code, launch
  task automatic seq(input logic [11:0] a, input logic [15:0] d, input logic [6:0] c);
    @(negedge clock_i);
    array_wr_i = 1'b1;
    array_addr_i = a;
    array_data_i = d;
    @(negedge clock_i);
    array_wr_i = 1'b0;
    cmd_wr_i = 1'b1;
    cmd_code_i = c;
    @(negedge clock_i);
    cmd_wr_i = 1'b0;
    stat_wr(5'h10);
  endtask

  // clears protection violation and access error
  task automatic clr();
    @(negedge clock_i);
    stat_wr(5'h06);
  endtask

  // edges counted from the launch edge until completion shows
  task automatic wait_done(input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (status_o.completion_flag !== 1'b1 && n < lim);
    chk("completion", 16'(status_o.completion_flag), 16'h0001);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(negedge clock_i);
    rd_addr_i = a;
    @(negedge clock_i);
    chk("read", rd_data_o, exp);
  endtask

  initial begin
    repeat (10) @(negedge clock_i);
    resetn_i = 1'b1;
    @(posedge clock_i);
    #1;
    chk("reset status", 16'(status_o), 16'h0018);
    seq(12'h010, 16'h0000, 7'h20);
    chk("no divider", 16'(status_o.access_error_flag), 16'h0001);
    clr();
    clkdiv_wr_i = 1'b1;
    clkdiv_data_i = 7'h3f;
    @(negedge clock_i);
    clkdiv_wr_i = 1'b0;
    chk("div loaded", 16'(divider_loaded_o), 16'h0001);
    seq(12'h010, 16'h0000, 7'h7f);
    chk("bad code", 16'(status_o.access_error_flag), 16'h0001);
    clr();
    prot_open_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      seq(12'h902, 16'h0000, bad[i]);
      chk("protection_violation_flag", 16'(status_o.protection_violation_flag), 16'h0001);
      chk("no launch", 16'(status_o.completion_flag), 16'h0001);
      clr();
    end
    prot_disable_i = 1'b1;
    seq(12'h5a6, 16'h0000, 7'h41);
    wait_done(6000);
    rd(12'h5a6, 16'hffff);
    seq(12'h010, 16'h0000, 7'h05);
    wait_done(3000);
    chk("verify cycles", 16'(n), 16'h080e);
    chk("erased", 16'(status_o.erased_flag), 16'h0001);
    seq(12'h010, 16'h1234, 7'h20);
    repeat (3) @(posedge clock_i);
    #1;
    chk("buf busy", 16'(status_o.buffer_empty_flag), 16'h0000);
    @(posedge clock_i);
    #1;
    chk("buf empty", 16'(status_o.buffer_empty_flag), 16'h0001);
    seq(12'h020, 16'h00ff, 7'h20);
    wait_done(2000);
    chk("buffered", 16'(n > 600), 16'h0001);
    rd(12'h010, 16'h1234);
    rd(12'h020, 16'h00ff);
    seq(12'h000, 16'h0000, 7'h05);
    wait_done(3000);
    chk("early stop", 16'(n < 2062), 16'h0001);
    chk("not erased", 16'(status_o.erased_flag), 16'h0000);
    seq(12'h012, 16'h0000, 7'h40);
    wait_done(2000);
    rd(12'h010, 16'hffff);
    rd(12'h020, 16'h00ff);
    seq(12'h022, 16'habcd, 7'h60);
    wait_done(3000);
    rd(12'h022, 16'habcd);
    rd(12'h020, 16'hffff);
    seq(12'h030, 16'h0000, 7'h40);
    repeat (6) @(posedge clock_i);
    seq(12'h000, 16'h0000, 7'h47);
    wait_done(400);
    // one tick is 64 cycles at this divider
    chk("abort time", 16'(n <= 261), 16'h0001);
    chk("abort err", 16'(status_o.access_error_flag), 16'h0001);
    clr();
    clkdiv_wr_i = 1'b1;
    clkdiv_data_i = 7'h47;
    @(negedge clock_i);
    clkdiv_wr_i = 1'b0;
    seq(12'h032, 16'h5555, 7'h20);
    wait_done(2000);
    // prescaled: eight timing periods of 64 cycles
    chk("prescale", 16'(n >= 512), 16'h0001);
    rd(12'h032, 16'h5555);
    print_verdict();
  end

  // whole run needs about 70 us
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule
